//--- include/pcd_pkg.sv
// package: constants, register map and types of the power control block
package pcd_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ  = 25_000_000;
	localparam int unsigned DEB_TIME_US  = 10_000;
	localparam int unsigned DEB_CYCLES   = (DEB_TIME_US * (CLK_FREQ_HZ / 1_000_000));
	localparam int unsigned DEB_W        = 18;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG  = 8'h00;
	localparam logic [7:0] ADDR_DUTY    = 8'h04;
	localparam logic [7:0] ADDR_ALMLVL  = 8'h08;
	localparam logic [7:0] ADDR_STATUS  = 8'h0C;
	localparam logic [7:0] ADDR_RESULT  = 8'h10;
	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] CONFIG_RST   = 8'h00;
	localparam logic [9:0] DUTY_FULL    = 10'h3E8;
	localparam logic [7:0] ALMLVL_RST   = 8'h55;
	localparam int unsigned NUM_ALARMS  = 10;
	localparam int unsigned ASSIGN_BASE = 6;
	localparam logic [9:0] ALARM_REV_MASK = 10'h007;
	localparam logic [7:0] FW_REV       = 8'h11;
	localparam logic [7:0] FW_REV_CLEAR = 8'h11;
	localparam int unsigned STAT_METHOD = 10;
	localparam int unsigned STAT_MANUAL = 12;
	localparam int unsigned STAT_SOURCE = 13;
	localparam int unsigned STAT_MODEL  = 15;
	localparam int unsigned RES_OUT     = 16;

	typedef enum logic [1:0] {
		EVFN_NONE   = 2'b00,
		EVFN_METHOD = 2'b01,
		EVFN_AUTOMAN = 2'b10
	} pcd_evfn_t;

	typedef enum logic [1:0] {
		METHOD_PHASE = 2'b00,
		METHOD_CYCLE = 2'b01,
		METHOD_CC    = 2'b10
	} pcd_method_t;

	typedef enum logic [1:0] {
		SRC_LINEAR = 2'b00,
		SRC_COMMS  = 2'b01,
		SRC_EXTRES = 2'b10,
		SRC_KEY    = 2'b11
	} pcd_src_t;

	typedef struct packed {
		logic      autoSrc;
		logic      extDutyEnable;
		logic      manualSourceSelect;
		logic      mainSettingDefaultSource;
		logic      phaseModeCc;
		logic      controlMethodParam;
		pcd_evfn_t eventInputFunctionSelect;
	} pcd_cfg_t;
endpackage : pcd_pkg

//--- core/pcd_power_ctrl.sv
// power controller: event/reset contact inputs, alarm latch, duty arithmetic, apb registers
`timescale 1ns/100ps
module pcd_power_ctrl #(
	parameter int unsigned DEB_CYCLES = pcd_pkg::DEB_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        eventContact,
	input  wire logic        resetContact,
	input  wire logic        ccModelStrap,
	input  wire logic [9:0]  nvDutyIn,
	input  wire logic        keyDutyWe,
	input  wire logic [9:0]  keyDutyData,
	input  wire logic        enterResetKey,
	input  wire logic [9:0]  extDutyValue,
	input  wire logic [9:0]  inputValue,
	input  wire logic [9:0]  baseUpValue,
	input  wire logic [9:0]  alarmDetect,
	output logic      [1:0]  controlMethod,
	output logic             manualMode,
	output logic      [1:0]  inputSource,
	output logic             methodParamVisible,
	output logic      [9:0]  effDuty,
	output logic      [9:0]  outValue,
	output logic             alarmOutputFirst,
	output logic             alarmOutputSecond,
	output logic             loadStop,
	output logic             nvWe,
	output logic      [9:0]  nvData
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// scale a by b, both in tenths of a percent, clamped to full scale
	function automatic logic [9:0] mulScale(input logic [9:0] a, input logic [9:0] b);
		logic [19:0] prod;
		logic [19:0] q;
		prod = 20'(a) * 20'(b);
		q = prod / 20'(pcd_pkg::DUTY_FULL);
		mulScale = (q > 20'(pcd_pkg::DUTY_FULL)) ? pcd_pkg::DUTY_FULL : q[9:0];
	endfunction : mulScale

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pcd_pkg::pcd_cfg_t cfg_r;
	logic [9:0]        duty_r;
	logic [7:0]        almLvl_r;
	logic [9:0]        alarm_r;
	logic              ccModel_r;
	logic              strapDone_r;
	logic              defaultManual_r;
	logic [1:0]        sync1_r;
	logic [1:0]        sync2_r;
	logic [1:0]        deb_r;
	logic [pcd_pkg::DEB_W-1:0] debCnt_r [2];
	logic              resetPrev_r;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	logic [1:0]        method_r;
	logic              manual_r;
	logic [1:0]        source_r;
	logic              visible_r;
	logic [9:0]        effDuty_r;
	logic [9:0]        outValue_r;
	logic              alarm_output_first_r;
	logic              alarm_output_second_r;
	logic              nvWe_r;

	// ----------------------------------------------------------------
	// contact inputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end
		else if (ce)
		begin
			sync1_r <= {resetContact, eventContact};
			sync2_r <= sync1_r;
		end
	end

	// a level must hold for the whole window; bounce restarts the count
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			deb_r       <= 2'h0;
			debCnt_r[0] <= '0;
			debCnt_r[1] <= '0;
			resetPrev_r <= 1'b0;
		end
		else if (ce)
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (sync2_r[i] == deb_r[i])
					debCnt_r[i] <= '0;
				else if (debCnt_r[i] >= pcd_pkg::DEB_W'(DEB_CYCLES - 1))
				begin
					deb_r[i]    <= sync2_r[i];
					debCnt_r[i] <= '0;
				end
				else
					debCnt_r[i] <= debCnt_r[i] + 1'b1;
			end
			resetPrev_r <= deb_r[1];
		end
	end

	logic clearPulse;
	assign clearPulse = deb_r[1] && !resetPrev_r;

	// ----------------------------------------------------------------
	// strap and applied default
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ccModel_r       <= 1'b0;
			strapDone_r     <= 1'b0;
			defaultManual_r <= 1'b0;
		end
		else if (ce)
		begin
			if (!strapDone_r)
			begin
				ccModel_r   <= ccModelStrap;
				strapDone_r <= 1'b1;
			end
			if (!strapDone_r || enterResetKey)
				defaultManual_r <= cfg_r.mainSettingDefaultSource;
		end
	end

	// ----------------------------------------------------------------
	// apb slave, one wait state
	// ----------------------------------------------------------------
	logic       access;
	logic       commit;
	logic [2:0] fnWr;
	logic       errNxt;
	logic [31:0] rdNxt;
	pcd_pkg::pcd_cfg_t cfgWr;
	assign access = psel && penable && !pready_r;
	assign commit = psel && penable && pready_r && pwrite && !pslverr_r;
	assign cfgWr  = pcd_pkg::pcd_cfg_t'(pwdata[7:0]);

	always_comb
	begin
		errNxt = 1'b0;
		rdNxt  = 32'h0000_0000;
		fnWr   = 3'h0;
		unique case (paddr)
			pcd_pkg::ADDR_CONFIG:
			begin
				rdNxt = {24'h00_0000, cfg_r};
				if (pwrite)
				begin
					if (cfgWr.eventInputFunctionSelect == 2'b11)
						errNxt = 1'b1;
					if (!ccModel_r && cfgWr.eventInputFunctionSelect != pcd_pkg::EVFN_NONE)
						errNxt = 1'b1;
					if (cfg_r.eventInputFunctionSelect == pcd_pkg::EVFN_METHOD &&
						cfgWr.controlMethodParam != cfg_r.controlMethodParam)
						errNxt = 1'b1;
				end
			end
			pcd_pkg::ADDR_DUTY:
			begin
				rdNxt = {22'h00_0000 & 22'h3F_FFFF, duty_r};
				if (pwrite && (!ccModel_r || pwdata[9:0] > pcd_pkg::DUTY_FULL))
					errNxt = 1'b1;
			end
			pcd_pkg::ADDR_ALMLVL:
				rdNxt = {24'h00_0000, almLvl_r};
			pcd_pkg::ADDR_STATUS:
			begin
				rdNxt = {16'h0000, ccModel_r, source_r, manual_r, method_r, alarm_r};
				errNxt = pwrite;
			end
			pcd_pkg::ADDR_RESULT:
			begin
				rdNxt = {6'h00, outValue_r, 6'h00, effDuty_r};
				errNxt = pwrite;
			end
			default:
				errNxt = 1'b1;
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (ce)
		begin
			pready_r  <= access;
			pslverr_r <= access && errNxt;
			prdata_r  <= (access && !pwrite && !errNxt) ? rdNxt : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg_r    <= pcd_pkg::pcd_cfg_t'(pcd_pkg::CONFIG_RST);
			almLvl_r <= pcd_pkg::ALMLVL_RST;
		end
		else if (ce && commit)
		begin
			if (paddr == pcd_pkg::ADDR_CONFIG)
				cfg_r <= cfgWr;
			if (paddr == pcd_pkg::ADDR_ALMLVL)
				almLvl_r <= pwdata[7:0];
		end
	end

	// internal duty; the copy reloads from non-volatile storage at start-up
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			duty_r <= pcd_pkg::DUTY_FULL;
			nvWe_r <= 1'b0;
		end
		else if (ce)
		begin
			nvWe_r <= 1'b0;
			if (!strapDone_r)
				duty_r <= (nvDutyIn > pcd_pkg::DUTY_FULL) ? pcd_pkg::DUTY_FULL : nvDutyIn;
			else if (keyDutyWe && keyDutyData <= pcd_pkg::DUTY_FULL)
			begin
				duty_r <= keyDutyData;
				nvWe_r <= 1'b1;
			end
			else if (commit && paddr == pcd_pkg::ADDR_DUTY)
			begin
				duty_r <= pwdata[9:0];
				nvWe_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// alarms
	// ----------------------------------------------------------------
	logic [9:0] detEnable;
	logic [9:0] lvl1;
	logic [9:0] lvl2;
	logic [9:0] clearMask;
	always_comb
	begin
		detEnable = 10'h3FF;
		lvl1      = 10'h3FF;
		lvl2      = 10'h000;
		for (int k = 0; k < 4; k++)
		begin
			// level 3 is not defined; it behaves as level 0
			lvl1[pcd_pkg::ASSIGN_BASE + k]      = (almLvl_r[2*k +: 2] == 2'b01);
			lvl2[pcd_pkg::ASSIGN_BASE + k]      = (almLvl_r[2*k +: 2] == 2'b10);
			detEnable[pcd_pkg::ASSIGN_BASE + k] = almLvl_r[2*k] ^ almLvl_r[2*k+1];
		end
		clearMask = (pcd_pkg::FW_REV >= pcd_pkg::FW_REV_CLEAR) ? 10'h3FF
			: ~pcd_pkg::ALARM_REV_MASK;
	end

	// a fresh detection in the clearing cycle stays latched
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			alarm_r <= 10'h000;
		else if (ce)
			alarm_r <= ((clearPulse ? (alarm_r & ~clearMask) : alarm_r)
				| (alarmDetect & detEnable)) & detEnable;
	end

	// ----------------------------------------------------------------
	// selection and duty arithmetic
	// ----------------------------------------------------------------
	pcd_pkg::pcd_evfn_t fnEff;
	logic [9:0] extUsed;
	logic [9:0] effNxt;
	logic [10:0] sumNxt;
	always_comb
	begin
		fnEff = ccModel_r ? cfg_r.eventInputFunctionSelect : pcd_pkg::EVFN_NONE;
		extUsed = cfg_r.extDutyEnable ? extDutyValue : pcd_pkg::DUTY_FULL;
		effNxt = mulScale(duty_r, extUsed);
		sumNxt = 11'(mulScale(effNxt, inputValue)) + 11'(baseUpValue);
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			method_r  <= pcd_pkg::METHOD_PHASE;
			manual_r  <= 1'b0;
			source_r  <= pcd_pkg::SRC_LINEAR;
			visible_r <= 1'b1;
		end
		else if (ce)
		begin
			if (ccModel_r && cfg_r.phaseModeCc)
				method_r <= pcd_pkg::METHOD_CC;
			else if (fnEff == pcd_pkg::EVFN_METHOD)
				method_r <= deb_r[0] ? pcd_pkg::METHOD_CYCLE : pcd_pkg::METHOD_PHASE;
			else
				method_r <= cfg_r.controlMethodParam ? pcd_pkg::METHOD_CYCLE
					: pcd_pkg::METHOD_PHASE;
			if (fnEff == pcd_pkg::EVFN_AUTOMAN)
			begin
				manual_r <= deb_r[0];
				source_r <= deb_r[0] ? (cfg_r.manualSourceSelect ? pcd_pkg::SRC_KEY
					: pcd_pkg::SRC_EXTRES) : (cfg_r.autoSrc ? pcd_pkg::SRC_COMMS
					: pcd_pkg::SRC_LINEAR);
			end
			else
			begin
				manual_r <= defaultManual_r;
				source_r <= defaultManual_r ? (cfg_r.manualSourceSelect ? pcd_pkg::SRC_KEY
					: pcd_pkg::SRC_EXTRES) : (cfg_r.autoSrc ? pcd_pkg::SRC_COMMS
					: pcd_pkg::SRC_LINEAR);
			end
			visible_r <= (fnEff != pcd_pkg::EVFN_METHOD);
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			effDuty_r  <= pcd_pkg::DUTY_FULL;
			outValue_r <= 10'h000;
			alarm_output_first_r   <= 1'b0;
			alarm_output_second_r   <= 1'b0;
		end
		else if (ce)
		begin
			effDuty_r  <= effNxt;
			outValue_r <= (sumNxt > 11'(pcd_pkg::DUTY_FULL)) ? pcd_pkg::DUTY_FULL
				: sumNxt[9:0];
			alarm_output_first_r   <= |(alarm_r & lvl1);
			alarm_output_second_r   <= |(alarm_r & lvl2);
		end
	end

	assign prdata             = prdata_r;
	assign pready             = pready_r;
	assign pslverr            = pslverr_r;
	assign controlMethod      = method_r;
	assign manualMode         = manual_r;
	assign inputSource        = source_r;
	assign methodParamVisible = visible_r;
	assign effDuty            = effDuty_r;
	assign outValue           = outValue_r;
	assign alarmOutputFirst   = alarm_output_first_r;
	assign alarmOutputSecond  = alarm_output_second_r;
	assign loadStop           = alarm_output_first_r;
	assign nvWe               = nvWe_r;
	assign nvData             = duty_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_method_write_err: assert property (@(posedge clock) disable iff (!resetn)
		(ce && access && pwrite && paddr == pcd_pkg::ADDR_CONFIG
		&& cfg_r.eventInputFunctionSelect == pcd_pkg::EVFN_METHOD
		&& pwdata[2] != cfg_r.controlMethodParam) |=> pslverr)
		else $error("method write not rejected");
	a_std_fn_err: assert property (@(posedge clock) disable iff (!resetn)
		(ce && access && pwrite && paddr == pcd_pkg::ADDR_CONFIG && !ccModel_r
		&& pwdata[1:0] != 2'b00) |=> pslverr)
		else $error("standard model accepted selector");
	a_cc_overrides: assert property (@(posedge clock) disable iff (!resetn)
		(ce && ccModel_r && cfg_r.phaseModeCc) |=> (!ce || controlMethod == pcd_pkg::METHOD_CC))
		else $error("constant current not applied");
	a_event_method: assert property (@(posedge clock) disable iff (!resetn)
		(ce && !(ccModel_r && cfg_r.phaseModeCc) && fnEff == pcd_pkg::EVFN_METHOD)
		|=> (!ce || controlMethod == {1'b0, $past(deb_r[0])}))
		else $error("event contact method wrong");
	a_event_manual: assert property (@(posedge clock) disable iff (!resetn)
		(ce && fnEff == pcd_pkg::EVFN_AUTOMAN) |=> (!ce || manualMode == $past(deb_r[0])))
		else $error("auto/manual not following contact");
	a_manual_source: assert property (@(posedge clock) disable iff (!resetn)
		(ce && manual_r == 1'b1 && !cfg_r.manualSourceSelect && $stable(cfg_r) && $stable(deb_r))
		|=> (!ce || inputSource == pcd_pkg::SRC_EXTRES || !manualMode))
		else $error("manual source wrong");
	a_alarm_clear: assert property (@(posedge clock) disable iff (!resetn)
		(ce && clearPulse && !(|alarmDetect)) |=> (!ce || alarm_r == 10'h000))
		else $error("alarms not cleared");
	a_alarm_hold: assert property (@(posedge clock) disable iff (!resetn)
		(ce && (alarmDetect[3] || (alarm_r[3] && !clearPulse)))
		|=> (!ce || alarm_r[3]) ##1 (!ce || loadStop))
		else $error("fatal alarm did not stop load");
	a_ext_disabled: assert property (@(posedge clock) disable iff (!resetn)
		(ce && !cfg_r.extDutyEnable && $stable(duty_r)) |=> (!ce || effDuty == $past(duty_r)))
		else $error("external duty used while disabled");
	a_debounce_hold: assert property (@(posedge clock) disable iff (!resetn)
		(ce && $changed(deb_r[0])) |-> $past(sync2_r[0]) == deb_r[0])
		else $error("debounce took unstable level");
endmodule : pcd_power_ctrl

//--- tb/pcd_contacts_model.sv
// partner model: bouncing contact switches and operator keypad
`timescale 1ns/100ps
module pcd_bouncer (
	input  wire logic clock,
	input  wire logic cmd,
	output logic      contact
);
	logic       last;
	logic [2:0] bnc;
	initial
	begin
		last = 1'b0;
		bnc = 3'h0;
		contact = 1'b0;
	end
	// real contacts chatter for a few cycles after every change
	always @(posedge clock)
	begin
		if (cmd != last)
		begin
			last <= cmd;
			bnc <= 3'h3;
		end
		else if (bnc != 3'h0)
			bnc <= bnc - 3'h1;
		contact <= (bnc != 3'h0) ? ~contact : last;
	end
endmodule : pcd_bouncer

module pcd_contacts_model (
	input  wire logic       clock,
	input  wire logic       evCmd,
	input  wire logic       rstCmd,
	input  wire logic       keyCmd,
	input  wire logic [9:0] keyVal,
	input  wire logic       entCmd,
	output logic            eventContact,
	output logic            resetContact,
	output logic            keyDutyWe,
	output logic     [9:0]  keyDutyData,
	output logic            enterResetKey
);
	pcd_bouncer evSw (.clock(clock), .cmd(evCmd), .contact(eventContact));
	pcd_bouncer rsSw (.clock(clock), .cmd(rstCmd), .contact(resetContact));
	initial
	begin
		keyDutyWe = 1'b0;
		keyDutyData = 10'h000;
		enterResetKey = 1'b0;
	end
	// keypad presses reach the controller as single-cycle pulses
	always @(posedge clock)
	begin
		keyDutyWe <= keyCmd;
		keyDutyData <= keyCmd ? keyVal : ~keyDutyData;
		enterResetKey <= entCmd;
	end
endmodule : pcd_contacts_model

//--- tb/pcd_power_ctrl_bench.sv
// testbench: apb master, behavioural model and comparisons
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module pcd_power_ctrl_bench;
	logic        clock, resetn, ce, psel, penable, pwrite, pready, pslverr, ccModelStrap;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        eventContact, resetContact, keyDutyWe, enterResetKey;
	logic [9:0]  nvDutyIn, keyDutyData, extDutyValue, inputValue, baseUpValue, alarmDetect;
	logic [1:0]  controlMethod, inputSource;
	logic        manualMode, methodParamVisible, alarmOutputFirst, alarmOutputSecond, loadStop;
	logic        nvWe, evCmd, rstCmd, keyCmd, entCmd;
	logic [9:0]  effDuty, outValue, nvData, keyVal;
	int          err_count, check_count, mCfg, mDuty, mEv, mDef, o, e, c;

	pcd_power_ctrl #(.DEB_CYCLES(8)) dut (.clock(clock), .resetn(resetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .eventContact(eventContact),
		.resetContact(resetContact), .ccModelStrap(ccModelStrap), .nvDutyIn(nvDutyIn),
		.keyDutyWe(keyDutyWe), .keyDutyData(keyDutyData), .enterResetKey(enterResetKey),
		.extDutyValue(extDutyValue), .inputValue(inputValue), .baseUpValue(baseUpValue),
		.alarmDetect(alarmDetect), .controlMethod(controlMethod), .manualMode(manualMode),
		.inputSource(inputSource), .methodParamVisible(methodParamVisible), .effDuty(effDuty),
		.outValue(outValue), .alarmOutputFirst(alarmOutputFirst),
		.alarmOutputSecond(alarmOutputSecond), .loadStop(loadStop), .nvWe(nvWe), .nvData(nvData));
	pcd_contacts_model sw (.clock(clock), .evCmd(evCmd), .rstCmd(rstCmd), .keyCmd(keyCmd),
		.keyVal(keyVal), .entCmd(entCmd), .eventContact(eventContact),
		.resetContact(resetContact), .keyDutyWe(keyDutyWe), .keyDutyData(keyDutyData),
		.enterResetKey(enterResetKey));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (err_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	// request stands until pready is seen high at a rising edge; answer taken there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic ee);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			finish_test();
		end
		q = prdata;
		ee = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic r;
		apb(1'b1, a, d, r);
		`CHK("write error", ee, r)
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex,
		input logic ee);
		logic r;
		apb(1'b0, a, 32'h0, r);
		`CHK("read error", ee, r)
		if (!ee)
			`CHK("read data", ex, q & m)
	endtask : rd

	task automatic settle;
		repeat (40) @(posedge clock);
	endtask : settle

	// model of selection, sourcing and duty arithmetic
	task automatic check_outs;
		int s, man, ext, eff;
		s = mCfg & 3;
		man = (s == 2) ? mEv : mDef;
		ext = mCfg[6] ? int'(extDutyValue) : 1000;
		eff = mDuty * ext / 1000;
		o = eff * int'(inputValue) / 1000 + int'(baseUpValue);
		if (o > 1000)
			o = 1000;
		e = mCfg[3] ? 2 : (s == 1) ? mEv : mCfg[2];
		`CHK("method", 2'(e), controlMethod)
		`CHK("manual", 1'(man), manualMode)
		`CHK("source", 2'(man ? (mCfg[5] ? 3 : 2) : mCfg[7]), inputSource)
		`CHK("visible", 1'(s != 1), methodParamVisible)
		`CHK("duty", 10'(eff), effDuty)
		rd(pcd_pkg::ADDR_RESULT, 32'h03FF03FF, {6'h0, 10'(o), 6'h0, 10'(eff)}, 1'b0);
	endtask : check_outs

	task automatic cfg(input int v);
		wr(pcd_pkg::ADDR_CONFIG, 32'(v), 1'b0);
		mCfg = v;
		settle();
	endtask : cfg

	task automatic ev(input int v);
		evCmd <= v[0];
		mEv = v;
		settle();
		check_outs();
	endtask : ev

	task automatic alarm(input int b, input int st, input logic f, input logic s2);
		alarmDetect <= 10'h1 << b;
		@(posedge clock);
		alarmDetect <= 10'h000;
		settle();
		rd(pcd_pkg::ADDR_STATUS, 32'h3FF, 32'(st), 1'b0);
		`CHK("alarm first", f, alarmOutputFirst)
		`CHK("alarm second", s2, alarmOutputSecond)
		`CHK("load stop", f, loadStop)
		rstCmd <= 1'b1;
		settle();
		rstCmd <= 1'b0;
		settle();
		rd(pcd_pkg::ADDR_STATUS, 32'h3FF, 32'h0, 1'b0);
	endtask : alarm

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
	endtask : do_reset
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, alarmDetect, baseUpValue} = '0;
		{evCmd, rstCmd, keyCmd, entCmd, keyVal, extDutyValue} = '0;
		{resetn, err_count, check_count, mCfg, mEv, mDef} = '0;
		ce = 1'b1;
		ccModelStrap = 1'b1;
		nvDutyIn = 10'h2BC;
		inputValue = 10'h3E8;
		mDuty = 700;
		void'($urandom(32'h51631FFC));
		do_reset();
		rd(pcd_pkg::ADDR_CONFIG, 32'hFF, 32'h0, 1'b0);
		rd(pcd_pkg::ADDR_ALMLVL, 32'hFF, 32'h55, 1'b0);
		rd(8'h14, 32'h0, 32'h0, 1'b1);
		wr(pcd_pkg::ADDR_STATUS, 32'h0, 1'b1);
		check_outs();
		ev(1);
		cfg(32'h10);
		check_outs();
		entCmd <= 1'b1;
		@(posedge clock);
		entCmd <= 1'b0;
		mDef = 1;
		settle();
		check_outs();
		cfg(32'h01);
		ev(0);
		ev(1);
		wr(pcd_pkg::ADDR_CONFIG, 32'h05, 1'b1);
		cfg(32'h09);
		ev(0);
		cfg(32'h82);
		check_outs();
		ev(1);
		wr(pcd_pkg::ADDR_CONFIG, 32'h03, 1'b1);
		wr(pcd_pkg::ADDR_DUTY, 32'h3E9, 1'b1);
		cfg(32'h40);
		wr(pcd_pkg::ADDR_DUTY, 32'h320, 1'b0);
		mDuty = 800;
		extDutyValue <= 10'h1F4;
		settle();
		check_outs();
		keyVal <= 10'h384;
		keyCmd <= 1'b1;
		@(posedge clock);
		keyCmd <= 1'b0;
		mDuty = 900;
		repeat (2) @(posedge clock);
		`CHK("nv write", 1'b1, nvWe)
		settle();
		`CHK("nv idle", 1'b0, nvWe)
		`CHK("stored duty", 10'h384, nvData)
		repeat (8)
		begin
			c = $urandom % 3;
			if ((mCfg & 3) == 1)
				c = c | (mCfg & 4);
			else
				c = c | ($urandom & 4);
			cfg(c | ($urandom & 32'hF8));
			mDuty = $urandom % 1001;
			wr(pcd_pkg::ADDR_DUTY, 32'(mDuty), 1'b0);
			extDutyValue <= 10'($urandom % 1001);
			inputValue <= 10'($urandom % 1001);
			baseUpValue <= 10'($urandom % 1001);
			ev($urandom % 2);
		end
		for (int b = 0; b < 10; b++)
			alarm(b, 1 << b, 1'b1, 1'b0);
		wr(pcd_pkg::ADDR_ALMLVL, 32'h56, 1'b0);
		alarm(6, 32'h40, 1'b0, 1'b1);
		wr(pcd_pkg::ADDR_ALMLVL, 32'h54, 1'b0);
		alarm(6, 0, 1'b0, 1'b0);
		ccModelStrap <= 1'b0;
		do_reset();
		wr(pcd_pkg::ADDR_CONFIG, 32'h01, 1'b1);
		wr(pcd_pkg::ADDR_DUTY, 32'h1F4, 1'b1);
		finish_test();
	end

	initial
	begin
		repeat (100000) @(posedge clock);
		err_count++;
		finish_test();
	end
endmodule : pcd_power_ctrl_bench
